//--- common/t16mc_defs.svh
// offsets, field positions, reset values and codes of the timer block
// assumes: included by bare name wherever a number is needed
`ifndef T16MC_DEFS_SVH
`define T16MC_DEFS_SVH

// ==========================================================
// register map (byte addresses)
`define T16MC_OFF_CTRLA  8'h00
`define T16MC_OFF_CTRLB  8'h04
`define T16MC_OFF_COUNT  8'h08
`define T16MC_OFF_CMPA   8'h0c
`define T16MC_OFF_CMPB   8'h10
`define T16MC_OFF_CAPT   8'h14
`define T16MC_OFF_STAT   8'h18

// ==========================================================
// writable masks and reset values
`define T16MC_CTRLA_WMASK 8'hf3
`define T16MC_CTRLB_WMASK 8'hdf
`define T16MC_CTRL_RESET  8'h00
`define T16MC_WORD_RESET  16'h0000
`define T16MC_STAT_OVF    0

// ==========================================================
// counter values
`define T16MC_TOP_MAX   16'hffff
`define T16MC_TOP_8BIT  16'h00ff
`define T16MC_TOP_9BIT  16'h01ff
`define T16MC_TOP_10BIT 16'h03ff
`define T16MC_BOTTOM    16'h0000
`define T16MC_STEP      16'h0001

// ==========================================================
// compare output mode codes
`define T16MC_OM_OFF    2'h0
`define T16MC_OM_TOGGLE 2'h1
`define T16MC_OM_CLEAR  2'h2
`define T16MC_OM_SET    2'h3

// ==========================================================
// clock select codes and prescaler terminal masks
`define T16MC_CS_STOP   3'h0
`define T16MC_CS_DIV1   3'h1
`define T16MC_CS_DIV8   3'h2
`define T16MC_CS_DIV64  3'h3
`define T16MC_CS_DIV256 3'h4
`define T16MC_CS_DIV1K  3'h5
`define T16MC_CS_EXTF   3'h6
`define T16MC_CS_EXTR   3'h7
`define T16MC_PM_DIV8   10'h007
`define T16MC_PM_DIV64  10'h03f
`define T16MC_PM_DIV256 10'h0ff
`define T16MC_PM_DIV1K  10'h3ff
`define T16MC_FILTER_LEN 4

`endif

//--- common/t16mc_pkg.sv
// types shared by the timer block
// assumes: numbers live in t16mc_defs.svh
package t16mc_pkg;

	typedef struct packed {
		logic [1:0] outmode_a;
		logic [1:0] outmode_b;
		logic [1:0] rsvd;
		logic [1:0] wave_lo;
	} t16mc_ctrl_a_t;

	typedef struct packed {
		logic       capture_filter_en;
		logic       capture_edge_sel;
		logic       rsvd;
		logic [1:0] wave_hi;
		logic [2:0] clk_sel;
	} t16mc_ctrl_b_t;

	typedef enum logic [3:0] {
		WM_NORMAL = 4'b0000, WM_PC8   = 4'b0001, WM_PC9   = 4'b0010, WM_PC10  = 4'b0011,
		WM_CTC_A  = 4'b0100, WM_FP8   = 4'b0101, WM_FP9   = 4'b0110, WM_FP10  = 4'b0111,
		WM_PFC_C  = 4'b1000, WM_PFC_A = 4'b1001, WM_PC_C  = 4'b1010, WM_PC_A  = 4'b1011,
		WM_CTC_C  = 4'b1100, WM_RSVD  = 4'b1101, WM_FP_C  = 4'b1110, WM_FP_A  = 4'b1111
	} t16mc_wave_t;

	typedef enum logic [1:0] {KIND_NONPWM = 2'b00, KIND_FAST = 2'b01, KIND_DUAL = 2'b10} t16mc_kind_t;
	typedef enum logic [1:0] {EVT_IMM = 2'b00, EVT_TOP = 2'b01, EVT_BOT = 2'b10, EVT_MAX = 2'b11} t16mc_evt_t;

	typedef struct packed {
		t16mc_kind_t kind;
		t16mc_evt_t  upd;
		t16mc_evt_t  ovf;
		logic [15:0] top;
	} t16mc_mode_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} t16mc_apb_req_t;

	typedef struct packed {
		logic out;
		logic oe_n;
	} t16mc_pin_t;

endpackage

//--- logic/t16mc_prescaler.sv
// timer clock enable: prescaled core clock or edges of the count pin
// assumes: count pin synchronous to ref_clk
`timescale 1ns/100ps
`include "t16mc_defs.svh"
module t16mc_prescaler (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [2:0] clk_sel,
	input  wire logic       ext_pin,
	output logic            tick
);
	logic [9:0] pre_reg;
	logic       ext_prev_reg;
	logic       tick_next;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_reg <= '0;
			ext_prev_reg <= 1'b0;
		end else begin
			pre_reg <= pre_reg + 10'h001;
			ext_prev_reg <= ext_pin;
		end
	end

	always_comb begin
		unique case (clk_sel)
			`T16MC_CS_STOP:   tick_next = 1'b0;
			`T16MC_CS_DIV1:   tick_next = 1'b1;
			`T16MC_CS_DIV8:   tick_next = (pre_reg & `T16MC_PM_DIV8) == `T16MC_PM_DIV8;
			`T16MC_CS_DIV64:  tick_next = (pre_reg & `T16MC_PM_DIV64) == `T16MC_PM_DIV64;
			`T16MC_CS_DIV256: tick_next = (pre_reg & `T16MC_PM_DIV256) == `T16MC_PM_DIV256;
			`T16MC_CS_DIV1K:  tick_next = (pre_reg & `T16MC_PM_DIV1K) == `T16MC_PM_DIV1K;
			`T16MC_CS_EXTF:   tick_next = ext_prev_reg & ~ext_pin;
			`T16MC_CS_EXTR:   tick_next = ~ext_prev_reg & ext_pin;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tick <= 1'b0;
		end else begin
			tick <= tick_next; // [R18]
		end
	end
endmodule

//--- logic/t16mc_capture_filter.sv
// capture pin noise filter and edge detector
// assumes: capture pin synchronous to ref_clk
`timescale 1ns/100ps
module t16mc_capture_filter #(
	parameter int FILTER_LEN = 4
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic pin,
	input  wire logic filter_en,
	input  wire logic edge_sel,
	output logic      capture
);
	if (FILTER_LEN < 2 || FILTER_LEN > 16) begin : g_bad_len
		$error("filter length out of range");
	end

	logic [FILTER_LEN-1:0] hist_reg;
	logic                  filt_reg;
	logic                  src_prev_reg;
	logic                  src;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hist_reg <= '0;
			filt_reg <= 1'b0;
		end else begin
			hist_reg <= {hist_reg[FILTER_LEN-2:0], pin};
			if (&hist_reg || ~|hist_reg) begin
				filt_reg <= hist_reg[0]; // [R20]
			end
		end
	end

	assign src = filter_en ? filt_reg : hist_reg[0];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			src_prev_reg <= 1'b0;
			capture <= 1'b0;
		end else begin
			src_prev_reg <= src;
			capture <= edge_sel ? (src & ~src_prev_reg) : (~src & src_prev_reg); // [R19]
		end
	end
endmodule

//--- logic/t16mc_timer.sv
// 16-bit timer/counter with mode control registers behind APB
// assumes: APB master, pins synchronous to ref_clk, port logic outside
//
// Behaviour
// [R01] nonzero output mode hands the pin from port logic to the compare output
// [R02] pin driver enabled only while the port direction bit selects output
// [R03] non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// [R04] fast PWM code 01 toggles A only in modes 14/15; else disconnected
// [R05] fast PWM: 10 clears on match, sets at TOP; 11 the reverse
// [R06] fast PWM: match equal to TOP ignored, TOP action still applied
// [R07] dual slope code 01 toggles A only in modes 8 to 11
// [R08] dual slope: 10 clears on up match, sets on down match; 11 reverse
// [R09] control A bits 3:2 read-only, read zero
// [R10] wave mode joins control B bits 4:3 above control A bits 1:0
// [R11] mode 0 normal, TOP 0xFFFF, immediate update, overflow at MAX
// [R12] mode 4 and 12 clear on match, TOP from compare A or capture
// [R13] modes 1-3, 5-7 fixed TOP 8/9/10 bit, update at TOP
// [R14] modes 8, 9 update and overflow at BOTTOM, TOP capture or compare A
// [R15] modes 10, 11, 14, 15 TOP from capture or compare A, update at TOP
// [R16] control B: filter 7, edge 6, reserved 5, wave 4:3, clock 2:0
// [R17] software avoids mode 13; treated here as normal counting
// [R18] clock select stops, prescales, or counts count pin edges
// [R19] edge select 0 captures falling, 1 rising edges
// [R20] filter changes only after four equal samples
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "t16mc_defs.svh"
module t16mc_timer #(
	parameter int FILTER_LEN = `T16MC_FILTER_LEN
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire t16mc_pkg::t16mc_apb_req_t apb_req,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      dir_a,
	input  wire logic                      dir_b,
	input  wire logic                      port_a_out,
	input  wire logic                      port_b_out,
	input  wire logic                      external_count_pin,
	input  wire logic                      capture_input_pin,
	output t16mc_pkg::t16mc_pin_t          compare_out_a,
	output t16mc_pkg::t16mc_pin_t          compare_out_b,
	output logic                           overflow_flag
);
	import t16mc_pkg::*;

	// ==========================================================
	// declarations
	t16mc_ctrl_a_t ctrl_a_reg;
	t16mc_ctrl_b_t ctrl_b_reg;
	logic [15:0]   count_reg;
	logic [15:0]   cmp_a_buf_reg;
	logic [15:0]   cmp_b_buf_reg;
	logic [15:0]   cmp_a_reg;
	logic [15:0]   cmp_b_reg;
	logic [15:0]   capt_reg;
	logic          down_reg;
	logic          block_reg;
	logic          oc_a_reg;
	logic          oc_b_reg;
	logic          tick;
	logic          capture_evt;
	t16mc_wave_t   wave;
	t16mc_mode_t   mode;
	logic          at_top;
	logic          at_bot;
	logic          match_a;
	logic          match_b;
	logic          tgl_a_ok;
	logic          conn_a;
	logic          conn_b;
	logic          upd_now;
	logic          ovf_set;
	logic          capt_live;
	logic          acc;
	logic          wr;
	logic          mapped;
	logic [7:0]    addr;

	// ==========================================================
	// functions
	function automatic t16mc_mode_t decode_mode(t16mc_wave_t w, logic [15:0] ca, logic [15:0] cap);
		t16mc_mode_t m;
		m = '{KIND_NONPWM, EVT_IMM, EVT_MAX, `T16MC_TOP_MAX};
		unique case (w)
			WM_NORMAL, WM_RSVD: m = '{KIND_NONPWM, EVT_IMM, EVT_MAX, `T16MC_TOP_MAX};
			WM_CTC_A:           m = '{KIND_NONPWM, EVT_IMM, EVT_MAX, ca};
			WM_CTC_C:           m = '{KIND_NONPWM, EVT_IMM, EVT_MAX, cap};
			WM_PC8:             m = '{KIND_DUAL, EVT_TOP, EVT_BOT, `T16MC_TOP_8BIT};
			WM_PC9:             m = '{KIND_DUAL, EVT_TOP, EVT_BOT, `T16MC_TOP_9BIT};
			WM_PC10:            m = '{KIND_DUAL, EVT_TOP, EVT_BOT, `T16MC_TOP_10BIT};
			WM_FP8:             m = '{KIND_FAST, EVT_TOP, EVT_TOP, `T16MC_TOP_8BIT};
			WM_FP9:             m = '{KIND_FAST, EVT_TOP, EVT_TOP, `T16MC_TOP_9BIT};
			WM_FP10:            m = '{KIND_FAST, EVT_TOP, EVT_TOP, `T16MC_TOP_10BIT};
			WM_PFC_C:           m = '{KIND_DUAL, EVT_BOT, EVT_BOT, cap};
			WM_PFC_A:           m = '{KIND_DUAL, EVT_BOT, EVT_BOT, ca};
			WM_PC_C:            m = '{KIND_DUAL, EVT_TOP, EVT_BOT, cap};
			WM_PC_A:            m = '{KIND_DUAL, EVT_TOP, EVT_BOT, ca};
			WM_FP_C:            m = '{KIND_FAST, EVT_TOP, EVT_TOP, cap};
			WM_FP_A:            m = '{KIND_FAST, EVT_TOP, EVT_TOP, ca};
		endcase
		return m;
	endfunction

	// a channel drives its pin for a nonzero code unless code 01 lacks a toggle in this mode
	function automatic logic om_connected(logic [1:0] om, logic tgl_ok);
		return (om != `T16MC_OM_OFF) && !(om == `T16MC_OM_TOGGLE && !tgl_ok);
	endfunction

	function automatic logic oc_next(
		logic [1:0]  om,
		t16mc_kind_t kind,
		logic        tgl_ok,
		logic        match,
		logic        top_evt,
		logic        eq_top,
		logic        down,
		logic        cur
	);
		logic v;
		v = cur;
		if (om == `T16MC_OM_TOGGLE) begin
			if (tgl_ok && match) begin
				v = ~cur;
			end
		end else if (om[1]) begin
			unique case (kind)
				KIND_NONPWM: begin
					if (match) begin
						v = om[0];
					end
				end
				KIND_FAST: begin
					if (top_evt) begin
						v = ~om[0];
					end else if (match && !eq_top) begin
						v = om[0];
					end
				end
				KIND_DUAL: begin
					if (match) begin
						v = down ? ~om[0] : om[0];
					end
				end
				default: v = cur;
			endcase
		end
		return v;
	endfunction

	// ==========================================================
	// clock enable and capture input
	t16mc_prescaler u_presc (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_sel (ctrl_b_reg.clk_sel),
		.ext_pin (external_count_pin),
		.tick    (tick)
	);

	t16mc_capture_filter #(.FILTER_LEN(FILTER_LEN)) u_capt (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.pin       (capture_input_pin),
		.filter_en (ctrl_b_reg.capture_filter_en),
		.edge_sel  (ctrl_b_reg.capture_edge_sel),
		.capture   (capture_evt)
	);

	// ==========================================================
	// mode decode
	assign wave = t16mc_wave_t'({ctrl_b_reg.wave_hi, ctrl_a_reg.wave_lo}); // [R10]
	assign mode = decode_mode(wave, cmp_a_reg, capt_reg); // [R11] [R12] [R13] [R14] [R15] [R17]
	assign at_top = count_reg == mode.top;
	assign at_bot = count_reg == `T16MC_BOTTOM;
	assign match_a = tick && !block_reg && count_reg == cmp_a_reg;
	assign match_b = tick && !block_reg && count_reg == cmp_b_reg;
	// capture pin is disconnected while it defines TOP
	assign capt_live = !(wave == WM_PFC_C || wave == WM_PC_C || wave == WM_CTC_C || wave == WM_FP_C);

	always_comb begin
		unique case (mode.kind)
			KIND_FAST: tgl_a_ok = wave == WM_FP_C || wave == WM_FP_A; // [R04]
			KIND_DUAL: tgl_a_ok = wave inside {WM_PFC_C, WM_PFC_A, WM_PC_C, WM_PC_A}; // [R07]
			default:   tgl_a_ok = 1'b1; // [R03]
		endcase
	end

	assign conn_a = om_connected(ctrl_a_reg.outmode_a, tgl_a_ok); // [R01]
	assign conn_b = om_connected(ctrl_a_reg.outmode_b, mode.kind == KIND_NONPWM); // [R01] [R04] [R07]

	always_comb begin
		unique case (mode.upd)
			EVT_TOP: upd_now = tick && at_top;
			EVT_BOT: upd_now = tick && at_bot;
			default: upd_now = 1'b1;
		endcase
	end

	always_comb begin
		unique case (mode.ovf)
			EVT_TOP: ovf_set = tick && at_top;
			EVT_BOT: ovf_set = tick && at_bot && down_reg;
			EVT_MAX: ovf_set = tick && count_reg == `T16MC_TOP_MAX;
			default: ovf_set = 1'b0;
		endcase
	end

	// ==========================================================
	// bus decode
	assign addr = apb_req.paddr;
	assign acc = apb_req.psel && apb_req.penable;
	assign wr = acc && apb_req.pwrite;
	assign mapped = addr inside {`T16MC_OFF_CTRLA, `T16MC_OFF_CTRLB, `T16MC_OFF_COUNT,
		`T16MC_OFF_CMPA, `T16MC_OFF_CMPB, `T16MC_OFF_CAPT, `T16MC_OFF_STAT};
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	always_comb begin
		prdata = '0;
		unique case (addr)
			`T16MC_OFF_CTRLA: prdata[7:0] = ctrl_a_reg; // [R09]
			`T16MC_OFF_CTRLB: prdata[7:0] = ctrl_b_reg; // [R16]
			`T16MC_OFF_COUNT: prdata[15:0] = count_reg;
			`T16MC_OFF_CMPA:  prdata[15:0] = cmp_a_buf_reg;
			`T16MC_OFF_CMPB:  prdata[15:0] = cmp_b_buf_reg;
			`T16MC_OFF_CAPT:  prdata[15:0] = capt_reg;
			`T16MC_OFF_STAT:  prdata[`T16MC_STAT_OVF] = overflow_flag;
			default:          prdata = '0;
		endcase
	end

	// ==========================================================
	// control registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_a_reg <= `T16MC_CTRL_RESET;
			ctrl_b_reg <= `T16MC_CTRL_RESET;
		end else if (wr) begin
			if (addr == `T16MC_OFF_CTRLA) begin
				ctrl_a_reg <= apb_req.pwdata[7:0] & `T16MC_CTRLA_WMASK; // [R09]
			end
			if (addr == `T16MC_OFF_CTRLB) begin
				ctrl_b_reg <= apb_req.pwdata[7:0] & `T16MC_CTRLB_WMASK; // [R16]
			end
		end
	end

	// ==========================================================
	// counter and direction
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_reg <= `T16MC_BOTTOM;
			down_reg <= 1'b0;
		end else if (wr && addr == `T16MC_OFF_COUNT) begin
			count_reg <= apb_req.pwdata[15:0];
		end else if (tick) begin
			if (mode.kind == KIND_DUAL) begin
				if (at_top && !down_reg) begin
					down_reg <= 1'b1;
					count_reg <= count_reg - `T16MC_STEP;
				end else if (at_bot && down_reg) begin
					down_reg <= 1'b0;
					count_reg <= count_reg + `T16MC_STEP;
				end else begin
					count_reg <= down_reg ? count_reg - `T16MC_STEP : count_reg + `T16MC_STEP;
				end
			end else begin
				down_reg <= 1'b0;
				count_reg <= at_top ? `T16MC_BOTTOM : count_reg + `T16MC_STEP; // [R12]
			end
		end
	end

	// a counter write suppresses the next timer clock's matches
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			block_reg <= 1'b0;
		end else if (wr && addr == `T16MC_OFF_COUNT) begin
			block_reg <= 1'b1;
		end else if (tick) begin
			block_reg <= 1'b0;
		end
	end

	// ==========================================================
	// compare buffers and active compare values
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmp_a_buf_reg <= `T16MC_WORD_RESET;
			cmp_b_buf_reg <= `T16MC_WORD_RESET;
		end else if (wr) begin
			if (addr == `T16MC_OFF_CMPA) begin
				cmp_a_buf_reg <= apb_req.pwdata[15:0];
			end
			if (addr == `T16MC_OFF_CMPB) begin
				cmp_b_buf_reg <= apb_req.pwdata[15:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmp_a_reg <= `T16MC_WORD_RESET;
			cmp_b_reg <= `T16MC_WORD_RESET;
		end else if (upd_now) begin
			cmp_a_reg <= cmp_a_buf_reg; // [R11] [R13] [R14] [R15]
			cmp_b_reg <= cmp_b_buf_reg;
		end
	end

	// ==========================================================
	// capture register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			capt_reg <= `T16MC_WORD_RESET;
		end else if (capture_evt && capt_live) begin
			capt_reg <= count_reg; // [R19]
		end else if (wr && addr == `T16MC_OFF_CAPT) begin
			capt_reg <= apb_req.pwdata[15:0];
		end
	end

	// ==========================================================
	// overflow flag: write one to clear, a new overflow wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			overflow_flag <= 1'b0;
		end else if (ovf_set) begin
			overflow_flag <= 1'b1; // [R11] [R13]
		end else if (wr && addr == `T16MC_OFF_STAT && apb_req.pwdata[`T16MC_STAT_OVF]) begin
			overflow_flag <= 1'b0;
		end
	end

	// ==========================================================
	// waveform outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			oc_a_reg <= 1'b0;
			oc_b_reg <= 1'b0;
		end else begin
			oc_a_reg <= oc_next(ctrl_a_reg.outmode_a, mode.kind, tgl_a_ok, match_a, // [R03] [R05] [R08]
				tick && at_top, cmp_a_reg == mode.top, down_reg, oc_a_reg); // [R06]
			oc_b_reg <= oc_next(ctrl_a_reg.outmode_b, mode.kind, mode.kind == KIND_NONPWM, match_b,
				tick && at_top, cmp_b_reg == mode.top, down_reg, oc_b_reg);
		end
	end

	assign compare_out_a.out = conn_a ? oc_a_reg : port_a_out; // [R01]
	assign compare_out_b.out = conn_b ? oc_b_reg : port_b_out;
	assign compare_out_a.oe_n = ~dir_a; // [R02]
	assign compare_out_b.oe_n = ~dir_b;

	// ==========================================================
	// checks
	sequence s_match_a_set;
		mode.kind == KIND_NONPWM && ctrl_a_reg.outmode_a == `T16MC_OM_SET && match_a;
	endsequence

	sequence s_fast_top_a;
		mode.kind == KIND_FAST && ctrl_a_reg.outmode_a[1] && tick && at_top;
	endsequence

	sequence s_dual_down_match;
		mode.kind == KIND_DUAL && ctrl_a_reg.outmode_a == `T16MC_OM_CLEAR && match_a && down_reg && !at_top;
	endsequence

	a_pin_dir_gate: assert property (@(posedge ref_clk) disable iff (rst) // [R02]
		compare_out_a.oe_n == !dir_a && compare_out_b.oe_n == !dir_b)
		else $error("pin driver not gated by direction");

	a_pin_override: assert property (@(posedge ref_clk) disable iff (rst) // [R01]
		(ctrl_a_reg.outmode_a == `T16MC_OM_SET) |-> compare_out_a.out == oc_a_reg)
		else $error("compare output did not take the pin");

	a_nonpwm_set: assert property (@(posedge ref_clk) disable iff (rst) // [R03]
		s_match_a_set |=> oc_a_reg && compare_out_a.out)
		else $error("set on match failed");

	a_fast_top_act: assert property (@(posedge ref_clk) disable iff (rst) // [R05]
		s_fast_top_a |=> oc_a_reg == !$past(ctrl_a_reg.outmode_a[0]))
		else $error("fast pwm top action wrong");

	a_fast_eq_top: assert property (@(posedge ref_clk) disable iff (rst) // [R06]
		s_fast_top_a ##0 (cmp_a_reg == mode.top) |=> oc_a_reg != $past(ctrl_a_reg.outmode_a[0]))
		else $error("match at top not ignored");

	a_fast_b_off: assert property (@(posedge ref_clk) disable iff (rst) // [R04]
		(mode.kind == KIND_FAST && ctrl_a_reg.outmode_b == `T16MC_OM_TOGGLE) |-> !conn_b)
		else $error("channel b toggled in fast pwm");

	a_dual_down_set: assert property (@(posedge ref_clk) disable iff (rst) // [R08]
		s_dual_down_match |=> oc_a_reg)
		else $error("down match did not set output");

	a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (rst) // [R09]
		(acc && addr == `T16MC_OFF_CTRLA) |-> prdata[3:2] == 2'b00 && prdata[31:8] == '0)
		else $error("reserved bits read nonzero");

	a_ctc_wrap: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
		(wave == WM_CTC_A && tick && at_top && !wr) |=> count_reg == `T16MC_BOTTOM)
		else $error("ctc did not clear at compare a");

	a_fast_ovf: assert property (@(posedge ref_clk) disable iff (rst) // [R13]
		(mode.kind == KIND_FAST && tick && at_top) |=> overflow_flag)
		else $error("fast pwm overflow not set at top");

	a_stop_idle: assert property (@(posedge ref_clk) disable iff (rst) // [R18]
		(ctrl_b_reg.clk_sel == `T16MC_CS_STOP) [*2] |-> !tick)
		else $error("stopped timer still ticks");
endmodule

//--- test/timer16_mode_control_test.sv
// bench for the timer control block: register reads and pin states checked from queues
// assumes: t16mc_timer, t16mc_pkg and t16mc_defs.svh compiled first
`timescale 1ns/100ps
`include "t16mc_defs.svh"
module timer16_mode_control_test;
	import t16mc_pkg::*;
	logic           ref_clk = 0, rst = 1, dir_a = 1, dir_b = 1, pa = 0, pb = 0, ext = 0, cap = 0, chk = 0;
	t16mc_apb_req_t req = '0;
	logic [31:0]    prdata, v;
	logic           pready, pslverr, overflow_flag;
	t16mc_pin_t     out_a, out_b;
	logic [32:0]    exp_q[$];
	logic [7:0]     pin_q[$];
	logic [32:0]    re;
	logic [7:0]     pe;
	logic [3:0]     wms[4] = '{4'd5, 4'd1, 4'd9, 4'd15};
	int             fails = 0, n_compared = 0;
	always #12.5 ref_clk = ~ref_clk;
	t16mc_timer t16mc_timer_inst (.ref_clk(ref_clk), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dir_a(dir_a), .dir_b(dir_b), .port_a_out(pa), .port_b_out(pb),
		.external_count_pin(ext), .capture_input_pin(cap), .compare_out_a(out_a), .compare_out_b(out_b),
		.overflow_flag(overflow_flag));
	// ==========================================================
	// monitors
	always @(posedge ref_clk) begin
		if (req.psel && req.penable && pready && !req.pwrite && exp_q.size() > 0) begin
			re = exp_q.pop_front();
			n_compared++;
			if ({pslverr, prdata} !== re) begin
				fails++;
				$display("wrong value at %0t: read %h expected %h", $time, {pslverr, prdata}, re);
			end
			if (req.paddr == `T16MC_OFF_STAT && overflow_flag !== re[`T16MC_STAT_OVF]) begin
				fails++;
				$display("wrong value at %0t: flag %b expected %b", $time, overflow_flag, re[`T16MC_STAT_OVF]);
			end
		end
		if (chk && pin_q.size() > 0) begin
			pe = pin_q.pop_front();
			n_compared++;
			if ((({out_a.oe_n, out_a.out, out_b.oe_n, out_b.out} ^ pe[3:0]) & pe[7:4]) !== 4'h0) begin
				fails++;
				$display("wrong value at %0t: pins %b expected %b", $time, {out_a, out_b}, pe[3:0]);
			end
		end
	end
	// ==========================================================
	// tasks
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic pin_chk(input logic [3:0] e, input logic [3:0] m);
		@(posedge ref_clk);
		pin_q.push_back({m, e});
		chk <= 1'b1;
		@(posedge ref_clk);
		chk <= 1'b0;
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge ref_clk) ext <= 1'b1;
			repeat (3) @(posedge ref_clk);
			ext <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask
	task automatic cap_case(input logic f, input logic e, input int len, input logic fall, input logic [15:0] x);
		cap <= 1'b0;
		repeat (10) @(posedge ref_clk);
		wr(`T16MC_OFF_CTRLB, {24'h0, f, e, 6'h0});
		wr(`T16MC_OFF_CAPT, 32'h0);
		cap <= 1'b1;
		repeat (len) @(posedge ref_clk);
		if (fall)
			cap <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rd(`T16MC_OFF_CAPT, {17'h0, x});
	endtask
	function automatic logic [31:0] ca(input logic [1:0] oa, input logic [1:0] ob, input logic [3:0] wm);
		return {24'h0, oa, ob, 2'b00, wm[1:0]};
	endfunction
	function automatic logic [31:0] cb(input logic [3:0] wm, input logic [2:0] cs);
		return {24'h0, 3'b000, wm[3:2], cs};
	endfunction
	// ==========================================================
	// tests
	initial begin
		repeat (40000) @(posedge ref_clk);
		fails++;
		print_verdict();
	end
	initial begin
		void'($urandom(5));
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`T16MC_OFF_CTRLA, 33'h0);
		rd(`T16MC_OFF_CTRLB, 33'h0);
		rd(8'h1c, 33'h100000000);
		repeat (4) begin
			v = $urandom;
			// low wave bits never 01 here, so the reserved mode cannot arise
			if (v[1:0] == 2'b01)
				v[1] = 1'b1;
			wr(`T16MC_OFF_CTRLA, v);
			rd(`T16MC_OFF_CTRLA, {25'h0, v[7:4], 2'b00, v[1:0]});
			v = $urandom;
			wr(`T16MC_OFF_CTRLB, v);
			rd(`T16MC_OFF_CTRLB, {25'h0, v[7:6], 1'b0, v[4:0]});
		end
		wr(`T16MC_OFF_CTRLA, 32'h0);
		wr(`T16MC_OFF_CTRLB, 32'h0);
		repeat (4) begin
			v = $urandom;
			{dir_b, dir_a, pb, pa} <= v[3:0];
			pin_chk({~v[2], v[0], ~v[3], v[1]}, 4'hf);
		end
		{dir_b, dir_a, pb, pa} <= 4'b1100;
		wr(`T16MC_OFF_CMPA, 32'h5);
		wr(`T16MC_OFF_CTRLB, cb(4'd0, 3'd1));
		for (int i = 0; i < 3; i++) begin
			wr(`T16MC_OFF_CTRLA, ca(2'd3 - 2'(i), 2'd0, 4'd0));
			wr(`T16MC_OFF_COUNT, 32'h0);
			repeat (20) @(posedge ref_clk);
			pin_chk({1'b0, i != 1, 2'b00}, 4'hf);
		end
		wr(`T16MC_OFF_STAT, 32'h1);
		wr(`T16MC_OFF_COUNT, 32'hfff0);
		repeat (30) @(posedge ref_clk);
		rd(`T16MC_OFF_STAT, 33'h1);
		wr(`T16MC_OFF_STAT, 32'h1);
		rd(`T16MC_OFF_STAT, 33'h0);
		wr(`T16MC_OFF_CTRLB, cb(4'd0, 3'd0));
		wr(`T16MC_OFF_COUNT, 32'h7);
		repeat (20) @(posedge ref_clk);
		rd(`T16MC_OFF_COUNT, 33'h7);
		for (int i = 0; i < 2; i++) begin
			wr(`T16MC_OFF_CTRLB, cb(4'd0, 3'd7 - 3'(i)));
			wr(`T16MC_OFF_COUNT, 32'h0);
			pulse(3);
			repeat (5) @(posedge ref_clk);
			rd(`T16MC_OFF_COUNT, 33'h3);
		end
		// mode order keeps every intermediate wave mode clear of the reserved one
		foreach (wms[k]) begin
			wr(`T16MC_OFF_CTRLA, ca(2'd1, 2'd1, wms[k]));
			wr(`T16MC_OFF_CTRLB, cb(wms[k], 3'd0));
			for (int j = 0; j < 2; j++) begin
				{pb, pa} <= {~j[0], j[0]};
				pin_chk({1'b0, j[0], 1'b0, ~j[0]}, k < 2 ? 4'hf : 4'h3);
			end
		end
		wr(`T16MC_OFF_CMPA, 32'h80);
		wr(`T16MC_OFF_CTRLB, cb(4'd5, 3'd1));
		wr(`T16MC_OFF_CTRLA, ca(2'd2, 2'd0, 4'd5));
		repeat (300) @(posedge ref_clk);
		wr(`T16MC_OFF_COUNT, 32'hf0);
		repeat (64) @(posedge ref_clk);
		pin_chk(4'b0100, 4'hc);
		repeat (128) @(posedge ref_clk);
		pin_chk(4'b0000, 4'hc);
		rd(`T16MC_OFF_STAT, 33'h1);
		wr(`T16MC_OFF_CMPA, 32'hff);
		repeat (300) @(posedge ref_clk);
		repeat (4) begin
			repeat ($urandom_range(90, 10)) @(posedge ref_clk);
			pin_chk(4'b0100, 4'hc);
		end
		wr(`T16MC_OFF_CTRLA, 32'h0);
		wr(`T16MC_OFF_CTRLB, 32'h0);
		wr(`T16MC_OFF_COUNT, 32'h1234);
		cap_case(1'b0, 1'b1, 8, 1'b0, 16'h1234);
		cap_case(1'b0, 1'b0, 8, 1'b0, 16'h0000);
		cap_case(1'b0, 1'b0, 8, 1'b1, 16'h1234);
		cap_case(1'b1, 1'b1, 3, 1'b1, 16'h0000);
		cap_case(1'b1, 1'b1, 4, 1'b1, 16'h1234);
		repeat (4) @(posedge ref_clk);
		print_verdict();
	end
endmodule
